// ==== bench/agp_master_model.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Graphics master on the far side of the port: answers grants with irdy
// Sideband delivery is never set up for 4X here, so the model keeps its
// sideband strobes quiet and marks no sideband items at all
module agp_master_model (
	input wire logic link_clk_i, // Port clock
	input wire logic rst_i, // Asynchronous reset
	input wire logic port_grant_n_i, // Grant from the hub
	input wire logic [2:0] grant_status_code_i, // Purpose of the grant
	input wire logic port_target_ready_oe_n_i, // Hub drives target-ready
	input wire logic slow_i, // Delay initiator-ready after the grant
	input wire logic frame_bad_i, // Misbehave: show frame during AGP work
	output logic port_initiator_ready_n_o,
	output logic port_cycle_frame_n_o
);
	logic busy_q; // Inside a granted data transfer
	logic seen_q; // Target-ready has been driven in this transfer
	logic [3:0] wait_q; // Cycles left before irdy

	////////////////////////////////////////////////////////////////////////////////
	// Track the transfer from grant until the hub releases target-ready
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			seen_q <= 1'b0;
			wait_q <= 4'h0;
		end else if (!port_grant_n_i && grant_status_code_i != 3'h7) begin
			// Start grants carry no data, so no irdy follows them
			busy_q <= 1'b1;
			seen_q <= 1'b0;
			wait_q <= slow_i ? 4'h9 : 4'h0;
		end else if (busy_q) begin
			if (wait_q != 4'h0) begin
				wait_q <= wait_q - 4'h1;
			end
			if (!port_target_ready_oe_n_i) begin
				seen_q <= 1'b1;
			end else if (seen_q) begin
				busy_q <= 1'b0;
			end
		end
	end

	// Once low, irdy stays low to the end: no waits after it, first read block never stalled
	assign port_initiator_ready_n_o = ~(busy_q && wait_q == 4'h0);
	// Frame idle through AGP work unless told to misbehave; no order to irdy assumed
	assign port_cycle_frame_n_o = ~(busy_q && frame_bad_i);
endmodule : agp_master_model

// ==== bench/agp_strobe_and_handshake_tb.sv ====
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module agp_strobe_and_handshake_tb;
	import agp_port_pkg::*;

	logic sys_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic cmd_valid = 1'b0;
	kind_t cmd_kind = KIND_START;
	logic [3:0] cmd_blocks = 4'h0;
	logic [31:0] cmd_word = 32'h0000_0000;
	logic mode = 1'b0; // 1 selects 0.8 V signalling
	logic hold = 1'b0;
	logic slow = 1'b0;
	logic frame_bad = 1'b0;
	logic cmd_ready, frame_err, irdy_n, frame_n, grant_n, trdy_n, trdy_oe_n, stop_n, stop_oe_n;
	logic ad_oe_n, stb, cmp, stb_h, cmp_h, stb_oe_n, inv_hi, inv_lo, inv_oe_n;
	logic [2:0] status;
	logic [31:0] ad;
	logic [3:0] be_n;
	int fails = 0;
	int n_tests = 0;
	int cycles = 0;
	// Monitor tallies, cleared per scenario
	int trdy_cnt, stb_rise, cmp_rise, cmp_bad, ad_bad, stb_drv, inv_drv, stop_drv, grants;
	logic [2:0] seen_status;
	logic prev_stb = 1'b0;
	logic prev_cmp = 1'b1;

	always #10 sys_clk = ~sys_clk;
	// Port clock; its rising edges never meet a core rising edge
	always #15 link_clk = ~link_clk;

	agp_port_target i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .link_clk_i(link_clk), .cmd_valid_i(cmd_valid),
		.cmd_kind_i(cmd_kind), .cmd_blocks_i(cmd_blocks), .cmd_word_i(cmd_word), .sig_mode_i(mode),
		.target_hold_i(hold), .cmd_ready_o(cmd_ready), .frame_error_o(frame_err),
		.port_initiator_ready_n_i(irdy_n), .port_cycle_frame_n_i(frame_n), .port_grant_n_o(grant_n),
		.grant_status_code_o(status), .port_target_ready_n_o(trdy_n), .port_target_ready_oe_n_o(trdy_oe_n),
		.port_target_stop_n_o(stop_n), .port_target_stop_oe_n_o(stop_oe_n), .port_addr_data_o(ad),
		.port_addr_data_oe_n_o(ad_oe_n), .port_cmd_byte_enables_n_o(be_n), .ad_low_strobe_o(stb),
		.ad_low_strobe_complement_o(cmp), .ad_high_strobe_o(stb_h), .ad_high_strobe_complement_o(cmp_h),
		.strobe_oe_n_o(stb_oe_n), .upper_inversion_flag_o(inv_hi), .lower_inversion_flag_o(inv_lo),
		.inversion_oe_n_o(inv_oe_n));

	agp_master_model i_master (.link_clk_i(link_clk), .rst_i(rst), .port_grant_n_i(grant_n),
		.grant_status_code_i(status), .port_target_ready_oe_n_i(trdy_oe_n), .slow_i(slow),
		.frame_bad_i(frame_bad), .port_initiator_ready_n_o(irdy_n), .port_cycle_frame_n_o(frame_n));

	////////////////////////////////////////////////////////////////////////////////
	// Pin monitor on the falling edge, where registered pins have settled
	always @(negedge link_clk) begin
		if (trdy_oe_n === 1'b0 && trdy_n === 1'b0) begin
			trdy_cnt++;
			if (stb && !prev_stb) stb_rise++;
			if (cmp && !prev_cmp) cmp_rise++;
		end
		if (ad_oe_n === 1'b0 && (ad !== cmd_word || be_n !== 4'h0)) ad_bad++;
		if (stb_oe_n === 1'b0 && (cmp !== ~stb || cmp_h !== ~stb_h || stb_h !== stb)) cmp_bad++;
		if (stb_oe_n === 1'b0) stb_drv++;
		if (inv_oe_n === 1'b0) inv_drv++;
		if (inv_oe_n === 1'b0 && (inv_hi | inv_lo) !== 1'b0) ad_bad++;
		if (stop_oe_n !== 1'b1 || stop_n !== 1'b1) stop_drv++;
		if (grant_n === 1'b0) begin
			grants++;
			seen_status = status;
		end
		prev_stb = stb;
		prev_cmp = cmp;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic clr;
		{trdy_cnt, stb_rise, cmp_rise, cmp_bad, ad_bad, stb_drv, inv_drv, stop_drv, grants} = '0;
		seen_status = 3'h5;
	endtask : clr

	// Offer one command and wait, bounded, for the port to go idle again
	task automatic run_cmd(input kind_t k, input logic [3:0] b, input logic [31:0] w);
		int n;
		n = 0;
		cmd_kind = k;
		cmd_blocks = b;
		cmd_word = w;
		cmd_valid = 1'b1;
		@(posedge sys_clk);
		#1;
		cmd_valid = 1'b0;
		while (cmd_ready !== 1'b1 && n < 3000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check("idle again", cmd_ready, 1'b1);
	endtask : run_cmd

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check("status idle", status, 3'h7);
		check("grant idle", grant_n, 1'b1);
		check("stop released", {stop_n, stop_oe_n}, 2'h3);
		check("strobes released", stb_oe_n, 1'b1);
	endtask : t_reset

	task automatic t_read1;
		clr();
		run_cmd(KIND_HP_READ, 4'h0, 32'hA5C3_1E7F);
		check("read status", seen_status, 3'h1);
		check("trdy cycles", trdy_cnt, 4);
		check("first strobe rises", stb_rise, 2);
		check("second strobe rises", cmp_rise, 2);
		check("complement", cmp_bad, 0);
		check("data under strobe", ad_bad, 0);
		check("inversion in 1.5 V", inv_drv, 0);
		check("stop", stop_drv, 0);
	endtask : t_read1

	task automatic t_read_hold;
		clr();
		mode = 1'b1;
		hold = 1'b1;
		slow = 1'b1;
		fork
			run_cmd(KIND_LP_READ, 4'h3, 32'h5A0F_C33C);
			begin
				repeat (40) @(posedge sys_clk);
				check("blocks while held", trdy_cnt, 4);
				#1 hold = 1'b0;
			end
		join
		check("read status", seen_status, 3'h0);
		check("trdy cycles", trdy_cnt, 12);
		check("first strobe rises", stb_rise, 6);
		check("second strobe rises", cmp_rise, 6);
		check("flags driven", inv_drv != 0, 1'b1);
		check("data and flags", ad_bad, 0);
		mode = 1'b0;
		slow = 1'b0;
	endtask : t_read_hold

	task automatic t_write;
		clr();
		slow = 1'b1;
		run_cmd(KIND_HP_WRITE, 4'h2, 32'h0000_0000);
		check("write status", seen_status, 3'h3);
		check("trdy cycles", trdy_cnt, 8);
		check("no hub strobe", stb_drv, 0);
		slow = 1'b0;
	endtask : t_write

	task automatic t_start;
		clr();
		run_cmd(KIND_START, 4'h0, 32'h0000_0000);
		check("start status", seen_status, 3'h7);
		check("one grant", grants, 1);
		check("no data", trdy_cnt, 0);
	endtask : t_start

	task automatic t_frame;
		clr();
		frame_bad = 1'b1;
		run_cmd(KIND_LP_READ, 4'h0, 32'h1234_ABCD);
		frame_bad = 1'b0;
		repeat (6) @(posedge sys_clk);
		check("frame flagged", frame_err, 1'b1);
		check("transfer unaffected", trdy_cnt, 4);
	endtask : t_frame

	task end_of_test;
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	// Hang guard, far above the few hundred cycles the scenarios need
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		#1 rst = 1'b0;
		t_reset();
		t_read1();
		t_read_hold();
		t_write();
		t_start();
		t_frame();
		end_of_test();
	end
endmodule : agp_strobe_and_handshake_tb

// ==== verilog/agp_port_defs.svh ====
`ifndef AGP_PORT_DEFS_SVH
`define AGP_PORT_DEFS_SVH

// Grant status codes shown while the grant is active
`define ST_LP_READ 3'h0
`define ST_HP_READ 3'h1
`define ST_HP_WRITE 3'h3
`define ST_START 3'h7

// Index of the last item of a four-clock block
`define LAST_BEAT 2'h3

// Reset values
`define BLOCKS_RST 4'h0
`define WORD_RST 32'h0000_0000

`endif

// ==== verilog/agp_port_pkg.sv ====
package agp_port_pkg;

	// Kind of work the core hands to the port
	typedef enum logic [1:0] {
		KIND_LP_READ,
		KIND_HP_READ,
		KIND_HP_WRITE,
		KIND_START
	} kind_t;

	// Link-side sequencer states
	typedef enum logic [2:0] {
		L_IDLE,
		L_GRANT,
		L_WAIT_IRDY,
		L_XFER,
		L_BOUND,
		L_END
	} link_state_t;

	// Core-domain state
	typedef struct packed {
		logic req;
		logic ready;
		logic ferr;
		kind_t kind;
		logic [3:0] blocks;
		logic [31:0] word;
	} core_st_t;

	// Link-domain state
	typedef struct packed {
		link_state_t state;
		kind_t kind;
		logic [3:0] left;
		logic [1:0] beat;
		logic [31:0] word;
		logic mode;
		logic ack;
		logic ferr;
		logic grant_n;
		logic [2:0] status;
		logic trdy_n;
		logic trdy_oe_n;
		logic ad_oe_n;
		logic [3:0] be_n;
		logic stb;
		logic stb_n;
		logic stb_oe_n;
		logic dbi;
		logic dbi_oe_n;
		logic stop_n;
		logic stop_oe_n;
	} link_st_t;

endpackage : agp_port_pkg

// ==== verilog/agp_port_target.sv ====
`timescale 1ns/10ps
`include "agp_port_defs.svh"
// Contract
// - Low strobe times data 15:0, byte-enables 1:0
// - High strobe times data 31:16, byte-enables 3:2
// - Each strobe driven with its differential complement
// - First strobe rises on odd items
// - Second strobe rises on even items
// - Upper strobe also times both inversion flags
// - PCI-protocol transfers keep plain PCI semantics
// - Frame marks PCI cycles, inactive during AGP
// - No frame to initiator-ready ordering in AGP
// - Target-ready once, or once per block
// - Target waits only between four-clock blocks
// - Stop only in frame-based transfers
// - Grant status encodes purpose of the grant
module agp_port_target (
	input wire logic sys_clk_i, // Core clock
	input wire logic rst_i, // Asynchronous reset, both domains
	input wire logic link_clk_i, // Port clock
	// Core command side
	input wire logic cmd_valid_i, // Command offered
	input wire agp_port_pkg::kind_t cmd_kind_i, // What the grant is for
	input wire logic [3:0] cmd_blocks_i, // Four-clock blocks, 0 means 1
	input wire logic [31:0] cmd_word_i, // Read data word returned
	input wire logic sig_mode_i, // 1 selects 0.8 V signalling
	input wire logic target_hold_i, // Ask for wait states between blocks
	output logic cmd_ready_o, // Idle, may take a command
	output logic frame_error_o, // Frame seen active during AGP work
	// Port pins
	input wire logic port_initiator_ready_n_i,
	input wire logic port_cycle_frame_n_i,
	output logic port_grant_n_o,
	output logic [2:0] grant_status_code_o,
	output logic port_target_ready_n_o,
	output logic port_target_ready_oe_n_o,
	output logic port_target_stop_n_o,
	output logic port_target_stop_oe_n_o,
	output logic [31:0] port_addr_data_o,
	output logic port_addr_data_oe_n_o,
	output logic [3:0] port_cmd_byte_enables_n_o,
	output logic ad_low_strobe_o,
	output logic ad_low_strobe_complement_o,
	output logic ad_high_strobe_o,
	output logic ad_high_strobe_complement_o,
	output logic strobe_oe_n_o,
	output logic upper_inversion_flag_o,
	output logic lower_inversion_flag_o,
	output logic inversion_oe_n_o
);
	import agp_port_pkg::*;

	////////////////////////////////////////////////////////////////
	// Decoders shared by several branches

	// Status code carried with a grant
	function automatic logic [2:0] status_of(input kind_t k);
		case (k)
			KIND_LP_READ: status_of = `ST_LP_READ;
			KIND_HP_READ: status_of = `ST_HP_READ;
			KIND_HP_WRITE: status_of = `ST_HP_WRITE;
			default: status_of = `ST_START;
		endcase
	endfunction : status_of

	// True when the hub supplies the data
	function automatic logic is_read(input kind_t k);
		is_read = (k == KIND_LP_READ) || (k == KIND_HP_READ);
	endfunction : is_read

	////////////////////////////////////////////////////////////////
	// Crossings

	sync_if #(.W(3)) c2l (); // Request toggle, mode, hold
	sync_if #(.W(2)) l2c (); // Done toggle, frame error
	sync_if #(.W(2)) pins (); // Initiator-ready, frame

	core_st_t core_q;
	core_st_t core_d;
	link_st_t link_q;
	link_st_t link_d;

	// Core levels into the port clock
	assign c2l.d = {core_q.req, sig_mode_i, target_hold_i};
	// Port levels back to the core clock
	assign l2c.d = {link_q.ack, link_q.ferr};
	// Pins are sampled on the port clock before any use
	assign pins.d = {port_initiator_ready_n_i, port_cycle_frame_n_i};

	bit_sync #(.W(3)) u_c2l (
		.clk_i(link_clk_i),
		.rst_i(rst_i),
		.s(c2l)
	);

	bit_sync #(.W(2)) u_l2c (
		.clk_i(sys_clk_i),
		.rst_i(rst_i),
		.s(l2c)
	);

	bit_sync #(.W(2)) u_pins (
		.clk_i(link_clk_i),
		.rst_i(rst_i),
		.s(pins)
	);

	// Synchronised views
	logic req_s; // Request toggle seen by port
	logic mode_s; // Signalling mode seen by port
	logic hold_s; // Wait request seen by port
	logic ack_s; // Done toggle seen by core
	logic ferr_s; // Frame error seen by core
	logic irdy_n_s; // Initiator-ready, active low
	logic frame_n_s; // Frame, active low

	assign {req_s, mode_s, hold_s} = c2l.q;
	assign {ack_s, ferr_s} = l2c.q;
	assign {irdy_n_s, frame_n_s} = pins.q;

	////////////////////////////////////////////////////////////////
	// Core side: one command in flight, toggle handshake

	// Command fields stay frozen until the port answers,
	// so the port may read them as settled words
	always_comb begin
		core_d = core_q;
		core_d.ferr = ferr_s;
		if (core_q.ready && cmd_valid_i) begin
			// Take the command and flip the request toggle
			core_d.kind = cmd_kind_i;
			core_d.blocks = cmd_blocks_i;
			core_d.word = cmd_word_i;
			core_d.req = ~core_q.req;
			core_d.ready = 1'b0;
		end else if (!core_q.ready && (ack_s == core_q.req)) begin
			// Port has finished the command
			core_d.ready = 1'b1;
		end
	end

	// Core register
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			core_q <= '{req: 1'b0, ready: 1'b1, ferr: 1'b0, kind: KIND_LP_READ,
				blocks: `BLOCKS_RST, word: `WORD_RST};
		end else begin
			core_q <= core_d;
		end
	end

	assign cmd_ready_o = core_q.ready;
	assign frame_error_o = core_q.ferr;

	////////////////////////////////////////////////////////////////
	// Port side sequencer

	// Grant, then blocks of four items framed by target-ready
	always_comb begin
		link_d = link_q;
		// The hub never asserts stop here; only frame-based cycles may
		link_d.stop_n = 1'b1;
		link_d.stop_oe_n = 1'b1;
		// Frame must stay inactive while AGP work is under way;
		// initiator-ready is judged on its own, never against frame
		if ((link_q.state != L_IDLE) && !frame_n_s) begin
			link_d.ferr = 1'b1;
		end
		case (link_q.state)
			L_IDLE: begin
				// Everything released between commands
				link_d.trdy_oe_n = 1'b1;
				link_d.ad_oe_n = 1'b1;
				link_d.stb_oe_n = 1'b1;
				link_d.dbi_oe_n = 1'b1;
				if (req_s != link_q.ack) begin
					link_d.kind = core_q.kind;
					link_d.left = (core_q.blocks == `BLOCKS_RST) ? 4'h1 : core_q.blocks;
					link_d.word = core_q.word;
					link_d.mode = mode_s;
					link_d.grant_n = 1'b0;
					link_d.status = status_of(core_q.kind);
					link_d.state = L_GRANT;
					if (is_read(core_q.kind)) begin
						// Supplier drives strobes; park them low so item one rises
						link_d.stb = 1'b0;
						link_d.stb_oe_n = 1'b0;
						link_d.ad_oe_n = 1'b0;
						// Inversion flags driven low only in 0.8 V mode
						link_d.dbi = 1'b0;
						link_d.dbi_oe_n = ~mode_s;
					end
				end
			end
			L_GRANT: begin
				link_d.grant_n = 1'b1;
				link_d.trdy_oe_n = 1'b0;
				if (link_q.kind == KIND_START) begin
					// Master now owns the bus; a frame-based cycle keeps plain PCI rules,
					// so target-ready is let go and never redefined here
					link_d.trdy_oe_n = 1'b1;
					link_d.state = L_END;
				end else if (is_read(link_q.kind)) begin
					// First read block goes straight out; master may not stall it
					link_d.trdy_n = 1'b0;
					link_d.stb = ~link_q.stb;
					link_d.beat = 2'h0;
					link_d.state = L_XFER;
				end else begin
					link_d.trdy_n = 1'b1;
					link_d.state = L_WAIT_IRDY;
				end
			end
			L_WAIT_IRDY: begin
				// Write starts only once the master has all its data
				if (!irdy_n_s) begin
					link_d.trdy_n = 1'b0;
					link_d.beat = 2'h0;
					link_d.state = L_XFER;
				end
			end
			L_XFER: begin
				if (link_q.beat == `LAST_BEAT) begin
					// Block complete; the only place a wait may start
					link_d.trdy_n = 1'b1;
					link_d.left = link_q.left - 4'h1;
					link_d.state = (link_q.left == 4'h1) ? L_END : L_BOUND;
				end else begin
					link_d.beat = link_q.beat + 2'h1;
					if (is_read(link_q.kind)) begin
						// Alternate edges: first rises on odd, second on even items
						link_d.stb = ~link_q.stb;
					end
				end
			end
			L_BOUND: begin
				// Hold off while the core asks; reads also need the master ready
				if (!hold_s && (!is_read(link_q.kind) || !irdy_n_s)) begin
					link_d.trdy_n = 1'b0;
					link_d.beat = 2'h0;
					link_d.state = L_XFER;
					if (is_read(link_q.kind)) begin
						link_d.stb = ~link_q.stb;
					end
				end
			end
			L_END: begin
				// Target-ready was driven high last cycle (never driven at all for a start grant); now let go
				link_d.trdy_oe_n = 1'b1;
				link_d.ad_oe_n = 1'b1;
				link_d.stb_oe_n = 1'b1;
				link_d.dbi_oe_n = 1'b1;
				link_d.stb = 1'b0;
				link_d.ack = ~link_q.ack;
				link_d.state = L_IDLE;
			end
			default: begin
				link_d.state = L_IDLE;
			end
		endcase
		// Complement kept in its own flop so both strobe pins leave registers
		link_d.stb_n = ~link_d.stb;
	end

	// Port register; pins come straight from here
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link_q <= '{state: L_IDLE, kind: KIND_LP_READ, left: `BLOCKS_RST, beat: 2'h0,
				word: `WORD_RST, mode: 1'b0, ack: 1'b0, ferr: 1'b0, grant_n: 1'b1,
				status: `ST_START, trdy_n: 1'b1, trdy_oe_n: 1'b1, ad_oe_n: 1'b1,
				be_n: 4'h0, stb: 1'b0, stb_n: 1'b1, stb_oe_n: 1'b1, dbi: 1'b0, dbi_oe_n: 1'b1,
				stop_n: 1'b1, stop_oe_n: 1'b1};
		end else begin
			link_q <= link_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// Pin map

	assign port_grant_n_o = link_q.grant_n;
	assign grant_status_code_o = link_q.status;
	assign port_target_ready_n_o = link_q.trdy_n;
	assign port_target_ready_oe_n_o = link_q.trdy_oe_n;
	assign port_target_stop_n_o = link_q.stop_n;
	assign port_target_stop_oe_n_o = link_q.stop_oe_n;
	assign port_addr_data_o = link_q.word;
	assign port_addr_data_oe_n_o = link_q.ad_oe_n;
	// Byte enables carry no meaning on read data; both halves ride the strobes
	assign port_cmd_byte_enables_n_o = link_q.be_n;
	// Both halves share one timing source, so the lanes stay aligned
	assign ad_low_strobe_o = link_q.stb;
	assign ad_high_strobe_o = link_q.stb;
	// Complement pins double as the second strobes in 0.8 V mode
	assign ad_low_strobe_complement_o = link_q.stb_n;
	assign ad_high_strobe_complement_o = link_q.stb_n;
	assign strobe_oe_n_o = link_q.stb_oe_n;
	assign upper_inversion_flag_o = link_q.dbi;
	assign lower_inversion_flag_o = link_q.dbi;
	assign inversion_oe_n_o = link_q.dbi_oe_n;

	////////////////////////////////////////////////////////////////
	// Checks

	// A block opens when target-ready falls
	sequence blk_open;
		$fell(link_q.trdy_n) && !link_q.trdy_oe_n;
	endsequence

	// Read grant being released
	sequence rd_grant;
		(link_q.state == L_GRANT) && is_read(link_q.kind);
	endsequence

	AST_BLOCK_NO_WAIT: assert property (@(posedge link_clk_i) disable iff (rst_i)
		blk_open |-> !link_q.trdy_n [*4] ##1 link_q.trdy_n)
		else $error("target-ready not held for exactly one block");

	AST_READ_FIRST: assert property (@(posedge link_clk_i) disable iff (rst_i)
		rd_grant |=> !link_q.trdy_n [*4])
		else $error("first read block did not start at once");

	AST_WRITE_IRDY: assert property (@(posedge link_clk_i) disable iff (rst_i)
		(link_q.state == L_WAIT_IRDY) && irdy_n_s |=> link_q.trdy_n)
		else $error("write block started before initiator-ready");

	AST_STATUS: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$fell(link_q.grant_n) |-> link_q.status == status_of(link_q.kind))
		else $error("grant status does not match grant purpose");

	AST_COMPLEMENT: assert property (@(posedge link_clk_i) disable iff (rst_i)
		!strobe_oe_n_o |-> (ad_low_strobe_complement_o == ~ad_low_strobe_o)
			&& (ad_high_strobe_complement_o == ~ad_high_strobe_o))
		else $error("strobe complement not inverse of strobe");

	AST_ITEM_EDGE: assert property (@(posedge link_clk_i) disable iff (rst_i)
		(link_q.state == L_XFER) && !link_q.stb_oe_n |-> link_q.stb != $past(link_q.stb))
		else $error("read item without a strobe edge");

	AST_LANES: assert property (@(posedge link_clk_i) disable iff (rst_i)
		(blk_open and is_read(link_q.kind)) |-> ad_low_strobe_o && ad_high_strobe_o
			&& !port_addr_data_oe_n_o)
		else $error("read block opened without both lane strobes high");

	AST_INVERSION: assert property (@(posedge link_clk_i) disable iff (rst_i)
		!inversion_oe_n_o |-> link_q.mode && !upper_inversion_flag_o && !lower_inversion_flag_o)
		else $error("inversion flags driven wrongly");

	AST_FRAME: assert property (@(posedge link_clk_i) disable iff (rst_i)
		(link_q.state != L_IDLE) && !frame_n_s |=> link_q.ferr)
		else $error("frame during AGP work not flagged");

endmodule : agp_port_target

// ==== verilog/bit_sync.sv ====
`timescale 1ns/10ps
// Two-flop level synchroniser, one lane per bit
module bit_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	sync_if.sync s
);
	// Both stages held in one state word
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_st_t;

	sync_st_t st_q;
	sync_st_t st_d;

	////////////////////////////////////////////////////////////////
	// Only the second stage reads the first; metastability settles there
	always_comb begin
		st_d.s1 = s.d;
		st_d.s2 = st_q.s1;
	end

	// Stages clear on reset
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign s.q = st_q.s2;
endmodule : bit_sync

// ==== verilog/sync_if.sv ====
`timescale 1ns/10ps
// Bundle around a two-flop synchroniser
interface sync_if #(parameter int W = 1);
	logic [W-1:0] d; // Level from the launching side
	logic [W-1:0] q; // Level safe for the capturing clock
	modport src (output d);
	modport sync (input d, output q);
	modport dst (input q);
endinterface : sync_if
